// File: design/twm_map.vh
// register offsets, field positions, codes and timing for the two-wire master
`ifndef TWM_MAP_VH
`define TWM_MAP_VH
`define TWM_REG_CTRL 3'h0
`define TWM_REG_STAT 3'h1
`define TWM_REG_DATA 3'h2
`define TWM_REG_IRQ 3'h3
`define TWM_REG_MASK 3'h4
`define TWM_CTRL_DONE 7
`define TWM_CTRL_ACKEN 6
`define TWM_CTRL_START 5
`define TWM_CTRL_STOP 4
`define TWM_CTRL_WCOL 3
`define TWM_CTRL_EN 2
`define TWM_IRQ_DONE 0
`define TWM_IRQ_ARB 1
`define TWM_IRQ_WCOL 2
`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_AW_ACK 8'h18
`define TWM_ST_AW_NACK 8'h20
`define TWM_ST_D_ACK 8'h28
`define TWM_ST_D_NACK 8'h30
`define TWM_ST_ARB 8'h38
`define TWM_ST_AR_ACK 8'h40
`define TWM_ST_AR_NACK 8'h48
`define TWM_ST_IDLE 8'hf8
`define TWM_CLK_NS 50
`define TWM_QTR_NS 2500
`define TWM_FREE_NS 4700
`endif

// File: design/twm_master_tx.v
// two-wire bus master transmitter with status codes and a strobe register port
`timescale 1ns/10ps
`include "twm_map.vh"
module twm_master_tx #(
   parameter QTR_CYC = `TWM_QTR_NS / `TWM_CLK_NS,
   parameter FREE_CYC = (`TWM_FREE_NS + `TWM_CLK_NS - 1) / `TWM_CLK_NS
) (
   input wire sys_clk_i,
   input wire rst_n_i,
   input wire ce_i,
   input wire [2:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [7:0] rdata_o,
   output wire irq_o,
   input wire scl_i,
   output wire scl_o,
   output reg scl_oe_o,
   input wire sda_i,
   output wire sda_o,
   output reg sda_oe_o,
   output reg master_rx_o
);
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_START = 3'h1;
   localparam [2:0] S_BIT = 3'h2;
   localparam [2:0] S_STOP = 3'h3;
   localparam [2:0] S_HOLD = 3'h4;

   reg scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
   reg bus_busy;
   reg [15:0] free_cnt;
   reg [15:0] qcnt;
   reg [2:0] state;
   reg [1:0] ph;
   reg [3:0] bitn;
   reg [7:0] shreg;
   reg is_addr, ack_seen, rep;
   reg step_done, ack_en, start_req, stop_req, wcol, enable;
   reg [7:0] code;
   reg [1:0] presc;
   reg [7:0] byte_buffer;
   reg [2:0] irq_st, irq_mask;
   reg go, ev_done, ev_arb, ev_wcol;
   reg [7:0] next_rdata;
   wire bus_free;
   wire tick;
   wire stall;

   // lines are open drain: only ever pulled low
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign irq_o = |(irq_st & irq_mask);
   assign bus_free = !bus_busy && (free_cnt == FREE_CYC[15:0]);
   // a released clock held low by another party stretches the phase
   assign stall = (state == S_BIT || state == S_START || state == S_STOP) && ph == 2'h2 && !scl_s;
   assign tick = (qcnt == QTR_CYC[15:0] - 16'h1) && !stall;

   // two-flop synchronisers, then previous values for edge detection
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_p <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_p <= 1'b1;
      end else if (ce_i) begin
         scl_m <= scl_i;
         scl_s <= scl_m;
         scl_p <= scl_s;
         sda_m <= sda_i;
         sda_s <= sda_m;
         sda_p <= sda_s;
      end
   end

   // bus busy between any start and stop seen on the wires, free after idle time
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         bus_busy <= 1'b0;
         free_cnt <= 16'h0000;
      end else if (ce_i) begin
         if (scl_s && sda_p && !sda_s)
            bus_busy <= 1'b1;
         else if (scl_s && !sda_p && sda_s)
            bus_busy <= 1'b0;
         if (bus_busy || !scl_s || !sda_s)
            free_cnt <= 16'h0000;
         else if (free_cnt != FREE_CYC[15:0])
            free_cnt <= free_cnt + 16'h0001;
      end
   end

   // read data mux, prescaler-free status code stands in the top bits
   always @* begin
      case (addr_i)
         `TWM_REG_CTRL: next_rdata = {step_done, ack_en, start_req, stop_req, wcol, enable, 2'h0};
         `TWM_REG_STAT: next_rdata = {code[7:3], 1'b0, presc};
         `TWM_REG_DATA: next_rdata = byte_buffer;
         `TWM_REG_IRQ: next_rdata = {5'h00, irq_st};
         `TWM_REG_MASK: next_rdata = {5'h00, irq_mask};
         default: next_rdata = 8'h00;
      endcase
   end

   // software side first, bus engine after it so hardware sets win
   always @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
         step_done <= 1'b0;
         ack_en <= 1'b0;
         start_req <= 1'b0;
         stop_req <= 1'b0;
         wcol <= 1'b0;
         enable <= 1'b0;
         code <= `TWM_ST_IDLE;
         presc <= 2'h0;
         byte_buffer <= 8'h00;
         irq_st <= 3'h0;
         irq_mask <= 3'h0;
         go <= 1'b0;
         ev_done <= 1'b0;
         ev_arb <= 1'b0;
         ev_wcol <= 1'b0;
         state <= S_IDLE;
         ph <= 2'h0;
         bitn <= 4'h0;
         shreg <= 8'h00;
         is_addr <= 1'b0;
         ack_seen <= 1'b0;
         rep <= 1'b0;
         qcnt <= 16'h0000;
         scl_oe_o <= 1'b0;
         sda_oe_o <= 1'b0;
         master_rx_o <= 1'b0;
      end else if (ce_i) begin
         go <= 1'b0;
         ev_done <= 1'b0;
         ev_arb <= 1'b0;
         ev_wcol <= 1'b0;
         if (rd_i)
            rdata_o <= next_rdata;
         // sticky events, a read clears but a same-cycle event survives
         irq_st <= ((rd_i && addr_i == `TWM_REG_IRQ) ? 3'h0 : irq_st) |
                   {ev_wcol, ev_arb, ev_done};
         if (wr_i) begin
            case (addr_i)
               `TWM_REG_CTRL: begin
                  ack_en <= wdata_i[`TWM_CTRL_ACKEN];
                  start_req <= wdata_i[`TWM_CTRL_START];
                  stop_req <= wdata_i[`TWM_CTRL_STOP];
                  enable <= wdata_i[`TWM_CTRL_EN];
                  if (wdata_i[`TWM_CTRL_DONE]) begin
                     step_done <= 1'b0;
                     go <= wdata_i[`TWM_CTRL_EN];
                  end
               end
               `TWM_REG_STAT: presc <= wdata_i[1:0];
               `TWM_REG_DATA: begin
                  if (step_done) begin
                     byte_buffer <= wdata_i;
                     wcol <= 1'b0;
                  end else begin
                     wcol <= 1'b1;
                     ev_wcol <= 1'b1;
                  end
               end
               `TWM_REG_MASK: irq_mask <= wdata_i[2:0];
               default: ;
            endcase
         end
         // quarter-bit timer runs only while a bus action is in progress
         if (state == S_IDLE || state == S_HOLD || tick)
            qcnt <= 16'h0000;
         else if (!stall)
            qcnt <= qcnt + 16'h0001;
         if (!enable) begin
            state <= S_IDLE;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
            code <= `TWM_ST_IDLE;
         end else begin
            case (state)
               S_IDLE: begin
                  // start only once the bus is free
                  if (start_req && !step_done && bus_free) begin
                     state <= S_START;
                     ph <= 2'h0;
                     rep <= 1'b0;
                  end
               end
               S_START: begin
                  if (tick) begin
                     ph <= ph + 2'h1;
                     case (ph)
                        2'h0: sda_oe_o <= 1'b0;
                        2'h1: scl_oe_o <= 1'b0;
                        2'h2: sda_oe_o <= 1'b1;
                        default: begin
                           scl_oe_o <= 1'b1;
                           code <= rep ? `TWM_ST_RSTART : `TWM_ST_START;
                           step_done <= 1'b1;
                           ev_done <= 1'b1;
                           state <= S_HOLD;
                        end
                     endcase
                  end
               end
               S_BIT: begin
                  if (tick) begin
                     ph <= ph + 2'h1;
                     case (ph)
                        2'h0: sda_oe_o <= (bitn != 4'h8) && !shreg[7];
                        2'h1: scl_oe_o <= 1'b0;
                        2'h2: begin
                           // released a one but the line reads low
                           if (bitn != 4'h8 && shreg[7] && !sda_s) begin
                              scl_oe_o <= 1'b0;
                              sda_oe_o <= 1'b0;
                              code <= `TWM_ST_ARB;
                              step_done <= 1'b1;
                              ev_done <= 1'b1;
                              ev_arb <= 1'b1;
                              state <= S_HOLD;
                           end
                           if (bitn == 4'h8)
                              ack_seen <= !sda_s;
                           else
                              shreg <= {shreg[6:0], 1'b0};
                        end
                        default: begin
                           scl_oe_o <= 1'b1;
                           if (bitn == 4'h8) begin
                              sda_oe_o <= 1'b0;
                              step_done <= 1'b1;
                              ev_done <= 1'b1;
                              state <= S_HOLD;
                              if (is_addr && !master_rx_o)
                                 code <= ack_seen ? `TWM_ST_AW_ACK : `TWM_ST_AW_NACK;
                              else if (is_addr)
                                 code <= ack_seen ? `TWM_ST_AR_ACK : `TWM_ST_AR_NACK;
                              else
                                 code <= ack_seen ? `TWM_ST_D_ACK : `TWM_ST_D_NACK;
                           end else begin
                              bitn <= bitn + 4'h1;
                           end
                        end
                     endcase
                  end
               end
               S_STOP: begin
                  if (tick) begin
                     ph <= ph + 2'h1;
                     case (ph)
                        2'h0: sda_oe_o <= 1'b1;
                        2'h1: scl_oe_o <= 1'b0;
                        2'h2: sda_oe_o <= 1'b0;
                        default: begin
                           stop_req <= 1'b0;
                           code <= `TWM_ST_IDLE;
                           // pending start follows once the bus is free
                           state <= S_IDLE;
                        end
                     endcase
                  end
               end
               S_HOLD: begin
                  // suspended until software clears the flag
                  if (go) begin
                     ph <= 2'h0;
                     bitn <= 4'h0;
                     case (code[7:3])
                        // address after start or repeated start
                        `TWM_ST_START >> 3, `TWM_ST_RSTART >> 3: begin
                           shreg <= byte_buffer;
                           is_addr <= 1'b1;
                           master_rx_o <= byte_buffer[0];
                           state <= S_BIT;
                        end
                        // release and become an unaddressed slave
                        `TWM_ST_ARB >> 3: begin
                           code <= `TWM_ST_IDLE;
                           state <= S_IDLE;
                        end
                        default: begin
                           if (stop_req) begin
                              state <= S_STOP;
                           end else if (start_req) begin
                              rep <= 1'b1;
                              state <= S_START;
                           end else if (code[7:3] >= (`TWM_ST_AW_ACK >> 3) &&
                                        code[7:3] <= (`TWM_ST_D_NACK >> 3)) begin
                              shreg <= byte_buffer;
                              is_addr <= 1'b0;
                              state <= S_BIT;
                           end
                        end
                     endcase
                  end
               end
               default: state <= S_IDLE;
            endcase
         end
      end
   end
endmodule

// File: verification/twm_master_tx_chk.sv
// port assertions for the two-wire master transmitter
`timescale 1ns/10ps
module twm_master_tx_chk #(
   parameter QTR_CYC = 50
) (
   input wire sys_clk_i,
   input wire rst_n_i,
   input wire ce_i,
   input wire [2:0] addr_i,
   input wire [7:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [7:0] rdata_o,
   input wire irq_o,
   input wire scl_i,
   input wire scl_o,
   input wire scl_oe_o,
   input wire sda_i,
   input wire sda_o,
   input wire sda_oe_o,
   input wire master_rx_o
);
   localparam int LAT = 400;
   int low_cnt;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n_i);
   // length of the current clock-low phase driven by the master
   always @(posedge sys_clk_i) begin
      if (!rst_n_i || !scl_oe_o)
         low_cnt <= 0;
      else if (ce_i)
         low_cnt <= low_cnt + 1;
   end
   property p_rst_idle;
      disable iff (1'b0) !rst_n_i && ce_i |=> !scl_oe_o && !sda_oe_o && !master_rx_o && !irq_o;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle in reset");
   property p_open_drain;
      !scl_o && !sda_o;
   endproperty
   a_open_drain: assert property (p_open_drain) else $error("line driven high");
   property p_rd_unmapped;
      rd_i && ce_i && addr_i > 3'h4 |=> rdata_o == 8'h00;
   endproperty
   a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
   property p_rd_hold;
      !rd_i |=> $stable(rdata_o);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
   property p_mask_quiet;
      wr_i && ce_i && addr_i == 3'h4 && wdata_i == 8'h00 |=> !irq_o;
   endproperty
   a_mask_quiet: assert property (p_mask_quiet) else $error("irq with all masked");
   property p_scl_low_min;
      $fell(scl_oe_o) |-> low_cnt >= QTR_CYC * 2 - 1;
   endproperty
   a_scl_low_min: assert property (p_scl_low_min) else $error("clock low phase short");
   property p_start_clock;
      $rose(sda_oe_o) && !scl_oe_o |-> ##[1:LAT] scl_oe_o;
   endproperty
   a_start_clock: assert property (p_start_clock) else $error("no clock after start");
   property p_stop_idle;
      $fell(sda_oe_o) && !scl_oe_o |=> (!scl_oe_o && !sda_oe_o) [*2];
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("lines busy after stop");
   property p_rx_hold;
      $rose(master_rx_o) |-> ##[0:LAT] scl_oe_o;
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("no hold after read address");
endmodule
bind twm_master_tx twm_master_tx_chk #(.QTR_CYC(QTR_CYC)) u_chk (.sys_clk_i, .rst_n_i, .ce_i,
   .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o, .scl_i, .scl_o, .scl_oe_o, .sda_i, .sda_o,
   .sda_oe_o, .master_rx_o);

// File: verification/twm_slave_mdl.sv
// behavioural slave receiver and competing master on the two-wire bus
`timescale 1ns/10ps
module twm_slave_mdl (
   input wire scl_i,
   input wire sda_i,
   input wire nack_i,
   input wire arb_i,
   output wire sda_oe_o,
   output reg [7:0] byte_o
);
   reg ack_drv = 1'b0;
   reg [7:0] shift = 8'h00;
   integer cnt = 0;
   // a competing master holds data low while asked to
   assign sda_oe_o = ack_drv | arb_i;
   // start or repeated start restarts the bit count
   always @(negedge sda_i) begin
      if (scl_i === 1'b1)
         cnt = 0;
   end
   // bits taken on the rising clock, msb first
   always @(posedge scl_i) begin
      if (cnt < 8)
         shift = {shift[6:0], sda_i};
      if (cnt == 7)
         byte_o = shift;
      cnt = cnt + 1;
   end
   always @(negedge scl_i) begin
      ack_drv = (cnt == 8) && !nack_i;
      if (cnt == 9)
         cnt = 0;
   end
endmodule

// File: verification/tb_top.sv
// self-checking bench for the two-wire master transmitter
`timescale 1ns/10ps
module tb_top;
   reg sys_clk_i = 1'b0;
   reg rst_n_i = 1'b0;
   reg [2:0] addr = 3'h0;
   reg [7:0] wdata = 8'h00;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg nack = 1'b0;
   reg arb = 1'b0;
   reg [7:0] d;
   wire [7:0] rdata;
   wire [7:0] got;
   wire irq, scl_oe, sda_oe, m_sda_oe, rx;
   wire scl = ~scl_oe;
   wire sda = ~(sda_oe | m_sda_oe);
   integer miscompares = 0;
   integer tests_run = 0;
   always #25 sys_clk_i = ~sys_clk_i;
   twm_master_tx #(.QTR_CYC(2), .FREE_CYC(2)) u_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .ce_i(1'b1), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .irq_o(irq), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(),
      .sda_oe_o(sda_oe), .master_rx_o(rx));
   twm_slave_mdl u_mdl (.scl_i(scl), .sda_i(sda), .nack_i(nack), .arb_i(arb),
      .sda_oe_o(m_sda_oe), .byte_o(got));
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task wr_reg(input [2:0] a, input [7:0] v);
      begin
         @(posedge sys_clk_i);
         addr <= a;
         wdata <= v;
         wr <= 1'b1;
         @(posedge sys_clk_i);
         wr <= 1'b0;
      end
   endtask
   task rd_reg(input [2:0] a, output [7:0] v);
      begin
         @(posedge sys_clk_i);
         addr <= a;
         rd <= 1'b1;
         @(posedge sys_clk_i);
         rd <= 1'b0;
         @(negedge sys_clk_i);
         v = rdata;
      end
   endtask
   // wait for the step-done interrupt, clear it and compare the code
   task done(input [7:0] code);
      integer i;
      begin
         i = 0;
         while (irq !== 1'b1 && i < 3000) begin
            @(posedge sys_clk_i);
            i = i + 1;
         end
         chk(irq, 1'b1);
         rd_reg(3'h3, d);
         chk(d[0], 1'b1);
         chk(irq, 1'b0);
         rd_reg(3'h1, d);
         chk(d & 8'hf8, code);
      end
   endtask
   task step(input [7:0] ctl, input [7:0] code);
      begin
         wr_reg(3'h0, ctl);
         done(code);
      end
   endtask
   task wait_code(input [7:0] code);
      integer i;
      begin
         i = 0;
         d = 8'h00;
         while ((d & 8'hf8) !== code && i < 500) begin
            rd_reg(3'h1, d);
            i = i + 1;
         end
         chk(d & 8'hf8, code);
      end
   endtask
   task t_write;
      begin
         step(8'ha4, 8'h08); // start sent
         wr_reg(3'h2, 8'h5a);
         step(8'h84, 8'h18); // address acked
         chk(got, 8'h5a); // address on wire
         wr_reg(3'h2, 8'hc3);
         wr_reg(3'h0, 8'h84);
         wr_reg(3'h2, 8'hff);
         done(8'h28); // data acked
         chk(got, 8'hc3); // late write dropped
         rd_reg(3'h0, d);
         chk(d[3], 1'b1); // collision flagged
         nack = 1'b1;
         wr_reg(3'h2, 8'h96);
         step(8'h84, 8'h30); // data refused
         chk(got, 8'h96); // byte sent
         wr_reg(3'h0, 8'h94);
         wait_code(8'hf8); // stop sent
         rd_reg(3'h0, d);
         chk(d[4], 1'b0); // stop request cleared
      end
   endtask
   task t_restart;
      begin
         nack = 1'b0;
         step(8'ha4, 8'h08);
         wr_reg(3'h2, 8'h5a);
         step(8'h84, 8'h18);
         step(8'ha4, 8'h10); // repeated start
         nack = 1'b1;
         wr_reg(3'h2, 8'h6c);
         step(8'h84, 8'h20); // other slave refuses
         chk(got, 8'h6c); // new address sent
         step(8'ha4, 8'h10); // repeated start after refusal
         wr_reg(3'h2, 8'h6d);
         step(8'h84, 8'h48); // read address sent
         chk(rx, 1'b1); // receive mode entered
         nack = 1'b0;
         step(8'hb4, 8'h08); // stop then start
         rd_reg(3'h0, d);
         chk(d[4], 1'b0); // stop request cleared
         wr_reg(3'h2, 8'h5a);
         step(8'h84, 8'h18);
         wr_reg(3'h0, 8'h94);
         wait_code(8'hf8);
      end
   endtask
   task t_arb;
      begin
         step(8'ha4, 8'h08);
         wr_reg(3'h2, 8'hff);
         arb = 1'b1;
         step(8'h84, 8'h38); // arbitration lost
         chk({scl_oe, sda_oe}, 2'b00); // lines let go
         arb = 1'b0;
         step(8'ha4, 8'h08); // start on free bus
         wr_reg(3'h2, 8'hff);
         arb = 1'b1;
         step(8'h84, 8'h38); // lost again
         wr_reg(3'h0, 8'h84);
         wait_code(8'hf8); // unaddressed state
         chk({scl_oe, sda_oe}, 2'b00); // lines released
         arb = 1'b0;
      end
   endtask
   task t_regs;
      begin
         wr_reg(3'h1, 8'h03);
         rd_reg(3'h1, d);
         chk(d[1:0], 2'h3); // prescaler kept
         chk(d & 8'hf8, 8'hf8); // code masked
         rd_reg(3'h7, d);
         chk(d, 8'h00);
         wr_reg(3'h4, 8'h00);
         wr_reg(3'h0, 8'ha4);
         wait_code(8'h08);
         chk(irq, 1'b0);
         wr_reg(3'h4, 8'h01);
         @(negedge sys_clk_i);
         chk(irq, 1'b1);
         wr_reg(3'h0, 8'h80);
         rd_reg(3'h0, d);
         chk(d[7], 1'b0); // flag cleared by writing one
         chk(d[2], 1'b0); // enable dropped
         rd_reg(3'h1, d);
         chk(d & 8'hf8, 8'hf8); // disabled interface idles
         chk({scl_oe, sda_oe}, 2'b00); // lines released
      end
   endtask
   task results;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, miscompares);
         if (miscompares == 0 && tests_run > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge sys_clk_i);
      rst_n_i <= 1'b1;
      wr_reg(3'h4, 8'h01);
      t_write;
      t_restart;
      t_arb;
      t_regs;
      results;
   end
   // watchdog against a hang
   initial begin
      repeat (40000) @(posedge sys_clk_i);
      miscompares = miscompares + 1;
      results;
   end
endmodule
